// [hdl/lcdhp_pkg.sv]
package lcdhp_pkg;

    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    localparam int          ADDR_W    = 17;
    localparam int          DATA_W    = 16;
    localparam logic [16:0] MEM_TOP   = 17'h1_3FFF;
    localparam logic [16:0] REG_BASE  = 17'h1_FFE0;
    localparam int          MEM_WORDS = (int'(MEM_TOP) + 1) / 2;
    localparam int          REG_WORDS = 16;

    // ------------------------------------------------------------------
    // Straps and reset values
    // ------------------------------------------------------------------
    localparam logic [2:0]  GENERIC_STRAPS = 3'h7;
    localparam logic [15:0] DATA_RST       = 16'h0000;

    // ------------------------------------------------------------------
    // Host timing, in REF_CLK_I cycles
    // ------------------------------------------------------------------
    localparam int BUS_CLK_HALF   = 2;
    localparam int SETUP_CYCLES   = 2;
    localparam int SETTLE_CYCLES  = 24;
    localparam int RECOVER_CYCLES = 16;
    localparam logic [3:0] LINK_RST_CYCLES = 4'hF;

    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_BUSY = 2'b01,
        LK_DONE = 2'b10
    } lcdhp_link_st_t;

    typedef enum logic [2:0] {
        HS_IDLE    = 3'b000,
        HS_SETUP   = 3'b001,
        HS_STROBE  = 3'b010,
        HS_WAIT    = 3'b011,
        HS_RECOVER = 3'b100
    } lcdhp_host_st_t;

    function automatic logic [15:0] lcdhp_swap16(input logic [15:0] d, input logic en);
        return en ? {d[7:0], d[15:8]} : d;
    endfunction

endpackage

// [hdl/lcdhp_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface lcdhp_if;
    logic        host_bus_clock_in;
    logic        cs_n;
    logic [16:0] host_addr_in;
    logic [15:0] host_data_o;
    logic        host_data_oe;
    logic [15:0] dev_data_o;
    logic        dev_data_oe;
    logic [15:0] host_data_io;
    logic        low_byte_write_strobe_n;
    logic        high_byte_strobe_n;
    logic        rd_n;
    logic        rd_wr_n;
    logic        wait_n_o;
    logic        wait_oe;
    logic        wait_line;

    // Undriven bus reads as zero; the wait line has a pull-up.
    assign host_data_io = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 16'h0000);
    assign wait_line    = wait_oe ? wait_n_o : 1'b1;

    modport dev (
        input  host_bus_clock_in, cs_n, host_addr_in, host_data_io,
        input  low_byte_write_strobe_n, high_byte_strobe_n, rd_n, rd_wr_n,
        output dev_data_o, dev_data_oe, wait_n_o, wait_oe
    );

    modport host (
        output host_bus_clock_in, cs_n, host_addr_in, host_data_o, host_data_oe,
        output low_byte_write_strobe_n, high_byte_strobe_n, rd_n, rd_wr_n,
        input  host_data_io, wait_line
    );
endinterface
`default_nettype wire

// [hdl/lcdhp_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module lcdhp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_q;

    always_comb
    begin
        nxt_meta = d_i;
        nxt_q    = meta_ff;
    end

    always_ff @(posedge clk_i)
    begin
        meta_ff <= nxt_meta;
        q_ff    <= nxt_q;
    end

    assign q_o = q_ff;
endmodule // lcdhp_sync
`default_nettype wire

// [hdl/lcdhp_device.sv]
// Overview of operation
// - Sixteen-bit data path straight to host.
// - Mode one: separate low/high byte write strobes.
// - Mode one: separate low/high byte read strobes.
// - Mode two: high strobe enables high byte.
// - Mode two: low write strobe is write.
// - Mode two: read strobe is the read enable.
// - Wait low until read valid/write accepted.
// - Arbitrate host against refresh, holding wait meanwhile.
// - Host inverts wait for active-high processors.
// - Bus status strap selects mode one/two.
// - Mode two: board ties read/write pin high.
// - Endian strap at reset sets byte order.
// - Separate bus clock times host transfers.
// - Host strobes synchronised inside the device.
// - Host decodes chip select from upper address.
// - 128K window, display memory from zero.
// - Registers fill the window's last 32 bytes.
// - Upper address ignored, so window aliases.
// - Host latches demultiplexed upper address bits.
// - Host adds decode when aliasing unwanted.
// - Straps latched as hardware reset releases.
`timescale 1ns/10ps
`default_nettype none
module lcdhp_device
    import lcdhp_pkg::*;
(
    // Core clock and reset
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_I,
    // Host link
    lcdhp_if.dev             bus,
    // Straps
    input  wire logic        BUS_STATUS_STRAP_I,
    input  wire logic        ENDIAN_STRAP_I,
    input  wire logic [2:0]  HOST_MODE_STRAPS_I,
    // Display refresh read port
    input  wire logic        REFRESH_REQ_I,
    input  wire logic [15:0] REFRESH_ADDR_I,
    output logic      [15:0] REFRESH_DATA_O,
    output logic             REFRESH_ACK_O,
    // Latched configuration
    output logic             CFG_ENABLED_O,
    output logic             CFG_MODE2_O,
    output logic             CFG_BIG_ENDIAN_O
);
    // ------------------------------------------------------------------
    // Core domain: straps
    // ------------------------------------------------------------------
    logic [4:0]  strap_q;
    logic        rst_d_ff;
    logic        lrst_ff, nxt_lrst;
    logic [3:0]  lrst_cnt_ff, nxt_lrst_cnt;
    logic [2:0]  cfg_ff;
    logic [2:0]  nxt_cfg;

    lcdhp_sync #(.W(5)) u_strap_sync (
        .clk_i (REF_CLK_I),
        .d_i   ({BUS_STATUS_STRAP_I, ENDIAN_STRAP_I, HOST_MODE_STRAPS_I}),
        .q_o   (strap_q)
    );

    // cfg_ff = {enabled, mode2, big endian}.
    always_comb
    begin
        nxt_cfg      = cfg_ff;
        nxt_lrst_cnt = (lrst_cnt_ff != 4'h0) ? lrst_cnt_ff - 4'h1 : 4'h0;
        nxt_lrst     = nxt_lrst_cnt != 4'h0;
        if (rst_d_ff && !RST_I)
            nxt_cfg = {strap_q[2:0] == GENERIC_STRAPS, strap_q[4], strap_q[3]};
    end

    // The link clock may stand still in reset, so the link side and the
    // handshake are held in reset for a while after release.
    always_ff @(posedge REF_CLK_I)
    begin
        rst_d_ff <= RST_I;
        if (RST_I)
        begin
            cfg_ff      <= 3'h0;
            lrst_cnt_ff <= LINK_RST_CYCLES;
            lrst_ff     <= 1'b1;
        end
        else
        begin
            cfg_ff      <= nxt_cfg;
            lrst_cnt_ff <= nxt_lrst_cnt;
            lrst_ff     <= nxt_lrst;
        end
    end

    // ------------------------------------------------------------------
    // Link domain registers, read across the toggle handshake
    // ------------------------------------------------------------------
    lcdhp_link_st_t lk_st_ff, nxt_st;
    logic [16:0] lk_addr_ff, nxt_addr;
    logic [15:0] lk_wd_ff, nxt_wd;
    logic [1:0]  lk_lanes_ff, nxt_lanes;
    logic        lk_rnw_ff, nxt_rnw;
    logic        lk_req_ff, nxt_req;
    logic        lk_ack_seen_ff, nxt_ack_seen;
    logic        wait_ff, nxt_wait;
    logic        woe_ff, nxt_woe;
    logic [15:0] dout_ff, nxt_dout;
    logic        doe_ff, nxt_doe;

    // ------------------------------------------------------------------
    // Core domain: arbiter and storage
    // ------------------------------------------------------------------
    logic [15:0] mem [0:MEM_WORDS-1];
    logic [15:0] regs [0:REG_WORDS-1];
    logic        req_q;
    logic        req_seen_ff, nxt_req_seen;
    logic        ack_ff, nxt_ack;
    logic [15:0] rdata_ff, nxt_rdata;
    logic        ref_last_ff, nxt_ref_last;
    logic [15:0] ref_data_ff, nxt_ref_data;
    logic        ref_ack_ff, nxt_ref_ack;
    logic        host_pend, ref_go, host_go, is_mem, is_reg;
    logic        mem_we, reg_we;
    logic [15:0] widx;

    lcdhp_sync u_req_sync (
        .clk_i (REF_CLK_I),
        .d_i   (lk_req_ff),
        .q_o   (req_q)
    );

    always_comb
    begin
        nxt_req_seen = req_seen_ff;
        nxt_ack      = ack_ff;
        nxt_rdata    = rdata_ff;
        nxt_ref_last = ref_last_ff;
        nxt_ref_data = ref_data_ff;
        nxt_ref_ack  = 1'b0;
        mem_we       = 1'b0;
        reg_we       = 1'b0;
        widx         = lk_addr_ff[16:1];
        is_mem       = lk_addr_ff <= MEM_TOP;
        is_reg       = lk_addr_ff >= REG_BASE;
        host_pend    = req_q != req_seen_ff;
        // Refresh and host alternate when both wait, so neither starves.
        ref_go       = REFRESH_REQ_I && (!host_pend || !ref_last_ff);
        host_go      = host_pend && !ref_go;
        if (ref_go)
        begin
            nxt_ref_last = 1'b1;
            nxt_ref_ack  = 1'b1;
            nxt_ref_data = (int'(REFRESH_ADDR_I) < MEM_WORDS) ? mem[REFRESH_ADDR_I] : DATA_RST;
        end
        else if (host_go)
        begin
            nxt_ref_last = 1'b0;
            nxt_req_seen = req_q;
            nxt_ack      = !ack_ff;
            mem_we       = !lk_rnw_ff && is_mem;
            reg_we       = !lk_rnw_ff && is_reg;
            if (is_mem)
                nxt_rdata = mem[widx];
            else if (is_reg)
                nxt_rdata = regs[lk_addr_ff[4:1]];
            else
                nxt_rdata = DATA_RST;
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I || lrst_ff)
        begin
            req_seen_ff <= 1'b0;
            ack_ff      <= 1'b0;
            rdata_ff    <= DATA_RST;
            ref_last_ff <= 1'b0;
            ref_data_ff <= DATA_RST;
            ref_ack_ff  <= 1'b0;
        end
        else
        begin
            req_seen_ff <= nxt_req_seen;
            ack_ff      <= nxt_ack;
            rdata_ff    <= nxt_rdata;
            ref_last_ff <= nxt_ref_last;
            ref_data_ff <= nxt_ref_data;
            ref_ack_ff  <= nxt_ref_ack;
        end
    end

    // Byte-lane writes; the array itself is not reset.
    always_ff @(posedge REF_CLK_I)
    begin
        if (mem_we && lk_lanes_ff[0])
            mem[widx][7:0] <= lk_wd_ff[7:0];
        if (mem_we && lk_lanes_ff[1])
            mem[widx][15:8] <= lk_wd_ff[15:8];
        if (reg_we && lk_lanes_ff[0])
            regs[lk_addr_ff[4:1]][7:0] <= lk_wd_ff[7:0];
        if (reg_we && lk_lanes_ff[1])
            regs[lk_addr_ff[4:1]][15:8] <= lk_wd_ff[15:8];
    end

    // ------------------------------------------------------------------
    // Link domain: synchronisers and decode
    // ------------------------------------------------------------------
    logic       lrst, ack_q;
    logic [2:0] lcfg;
    logic [4:0] pin_q;
    logic [32:0] bus_q;
    logic       s_cs_n, acc_wr, acc_rd;
    logic [1:0] lanes;

    lcdhp_sync #(.W(5)) u_cross_sync (
        .clk_i (bus.host_bus_clock_in),
        .d_i   ({lrst_ff, ack_ff, cfg_ff}),
        .q_o   ({lrst, ack_q, lcfg})
    );

    lcdhp_sync #(.W(5)) u_pin_sync (
        .clk_i (bus.host_bus_clock_in),
        .d_i   ({bus.cs_n, bus.low_byte_write_strobe_n, bus.high_byte_strobe_n,
                 bus.rd_n, bus.rd_wr_n}),
        .q_o   (pin_q)
    );

    lcdhp_sync #(.W(33)) u_bus_sync (
        .clk_i (bus.host_bus_clock_in),
        .d_i   ({bus.host_addr_in, bus.host_data_io}),
        .q_o   (bus_q)
    );

    always_comb
    begin
        s_cs_n = pin_q[4];
        if (lcfg[1])
        begin
            acc_wr = !pin_q[3];
            acc_rd = !pin_q[1];
            lanes  = {!pin_q[2], !bus_q[16]};
        end
        else
        begin
            acc_wr = !pin_q[3] || !pin_q[2];
            acc_rd = !pin_q[1] || !pin_q[0];
            lanes  = acc_wr ? {!pin_q[2], !pin_q[3]} : {!pin_q[0], !pin_q[1]};
        end
        acc_wr = acc_wr && !s_cs_n && lcfg[2];
        acc_rd = acc_rd && !s_cs_n && lcfg[2];
    end

    // ------------------------------------------------------------------
    // Link domain: transfer state machine
    // ------------------------------------------------------------------
    // Address and data pass two flip-flops like the strobes; the host sets
    // them before the strobes fall, so they have settled when one is seen.
    // Strobes of one access must fall together; a lane that falls a bus
    // clock later than its partner is missed.
    always_comb
    begin
        nxt_st       = lk_st_ff;
        nxt_addr     = lk_addr_ff;
        nxt_wd       = lk_wd_ff;
        nxt_lanes    = lk_lanes_ff;
        nxt_rnw      = lk_rnw_ff;
        nxt_req      = lk_req_ff;
        nxt_ack_seen = lk_ack_seen_ff;
        nxt_wait     = wait_ff;
        nxt_dout     = dout_ff;
        nxt_doe      = doe_ff;
        unique case (lk_st_ff)
            LK_IDLE:
                if (acc_wr || acc_rd)
                begin
                    nxt_addr  = bus_q[32:16];
                    nxt_wd    = lcdhp_swap16(bus_q[15:0], lcfg[0]);
                    nxt_lanes = lcfg[0] ? {lanes[0], lanes[1]} : lanes;
                    nxt_rnw   = !acc_wr;
                    nxt_req   = !lk_req_ff;
                    nxt_wait  = 1'b0;
                    nxt_st    = LK_BUSY;
                end
            LK_BUSY:
                if (ack_q != lk_ack_seen_ff)
                begin
                    nxt_ack_seen = ack_q;
                    nxt_wait     = 1'b1;
                    nxt_dout     = lcdhp_swap16(rdata_ff, lcfg[0]);
                    nxt_doe      = lk_rnw_ff;
                    nxt_st       = LK_DONE;
                end
            LK_DONE:
                if (!acc_wr && !acc_rd)
                begin
                    nxt_doe = 1'b0;
                    nxt_st  = LK_IDLE;
                end
            default:
                nxt_st = LK_IDLE;
        endcase
        nxt_doe = nxt_doe && !s_cs_n;
        nxt_woe = !s_cs_n && (nxt_st != LK_IDLE);
    end

    always_ff @(posedge bus.host_bus_clock_in)
    begin
        if (lrst)
        begin
            lk_st_ff       <= LK_IDLE;
            lk_addr_ff     <= 17'h0_0000;
            lk_wd_ff       <= DATA_RST;
            lk_lanes_ff    <= 2'h0;
            lk_rnw_ff      <= 1'b1;
            lk_req_ff      <= 1'b0;
            lk_ack_seen_ff <= 1'b0;
            wait_ff        <= 1'b1;
            woe_ff         <= 1'b0;
            dout_ff        <= DATA_RST;
            doe_ff         <= 1'b0;
        end
        else
        begin
            lk_st_ff       <= nxt_st;
            lk_addr_ff     <= nxt_addr;
            lk_wd_ff       <= nxt_wd;
            lk_lanes_ff    <= nxt_lanes;
            lk_rnw_ff      <= nxt_rnw;
            lk_req_ff      <= nxt_req;
            lk_ack_seen_ff <= nxt_ack_seen;
            wait_ff        <= nxt_wait;
            woe_ff         <= nxt_woe;
            dout_ff        <= nxt_dout;
            doe_ff         <= nxt_doe;
        end
    end

    assign bus.wait_n_o      = wait_ff;
    assign bus.wait_oe       = woe_ff;
    assign bus.dev_data_o    = dout_ff;
    assign bus.dev_data_oe   = doe_ff;
    assign REFRESH_DATA_O    = ref_data_ff;
    assign REFRESH_ACK_O     = ref_ack_ff;
    assign CFG_ENABLED_O     = cfg_ff[2];
    assign CFG_MODE2_O       = cfg_ff[1];
    assign CFG_BIG_ENDIAN_O  = cfg_ff[0];
endmodule // lcdhp_device
`default_nettype wire

// [hdl/lcdhp_host.sv]
`timescale 1ns/10ps
`default_nettype none
module lcdhp_host
    import lcdhp_pkg::*;
(
    // Clock and reset
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_I,
    // Link to the device
    lcdhp_if.host            bus,
    // Board options
    input  wire logic        MODE2_I,
    input  wire logic        STRICT_DECODE_I,
    // Command
    input  wire logic        CMD_VALID_I,
    input  wire logic        CMD_WRITE_I,
    input  wire logic [25:0] CMD_ADDR_I,
    input  wire logic [15:0] CMD_WDATA_I,
    input  wire logic [1:0]  CMD_BYTE_EN_I,
    output logic             CMD_READY_O,
    // Response
    output logic             RSP_VALID_O,
    output logic      [15:0] RSP_RDATA_O,
    output logic             CPU_WAIT_O
);
    lcdhp_host_st_t st_ff, nxt_st;
    logic [4:0]  cnt_ff, nxt_cnt;
    logic [1:0]  div_ff, nxt_div;
    logic        bclk_ff, nxt_bclk;
    logic        cs_n_ff, nxt_cs_n;
    logic [16:0] addr_ff, nxt_addr;
    logic [15:0] dout_ff, nxt_dout;
    logic        doe_ff, nxt_doe;
    logic [3:0]  stb_ff, nxt_stb;
    logic        wr_ff, nxt_wr;
    logic [1:0]  be_ff, nxt_be;
    logic        rsp_ff, nxt_rsp;
    logic [15:0] rdata_ff, nxt_rdata;
    logic        cpu_wait_ff, nxt_cpu_wait;
    logic        wait_q;

    lcdhp_sync u_wait_sync (
        .clk_i (REF_CLK_I),
        .d_i   (bus.wait_line),
        .q_o   (wait_q)
    );

    // ------------------------------------------------------------------
    // Strobe mapping, {we0_n, we1_n, rd_n, rd_wr_n}
    // ------------------------------------------------------------------
    function automatic logic [3:0] strobes(input logic m2, input logic wr, input logic [1:0] be);
        if (m2)
            return {!wr, !be[1], wr, 1'b1};
        return {!(wr && be[0]), !(wr && be[1]), !(!wr && be[0]), !(!wr && be[1])};
    endfunction

    always_comb
    begin
        nxt_st       = st_ff;
        nxt_cnt      = cnt_ff + 5'h01;
        nxt_div      = div_ff + 2'h1;
        nxt_bclk     = bclk_ff;
        nxt_cs_n     = cs_n_ff;
        nxt_addr     = addr_ff;
        nxt_dout     = dout_ff;
        nxt_doe      = doe_ff;
        nxt_stb      = stb_ff;
        nxt_wr       = wr_ff;
        nxt_be       = be_ff;
        nxt_rsp      = 1'b0;
        nxt_rdata    = rdata_ff;
        nxt_cpu_wait = !wait_q;
        // The host makes the link clock by dividing its own.
        if (div_ff == 2'(BUS_CLK_HALF - 1))
        begin
            nxt_div  = 2'h0;
            nxt_bclk = !bclk_ff;
        end
        unique case (st_ff)
            HS_IDLE:
                if (CMD_VALID_I)
                begin
                    nxt_wr = CMD_WRITE_I;
                    nxt_be = CMD_BYTE_EN_I;
                    nxt_cnt = 5'h00;
                    if (STRICT_DECODE_I && (CMD_ADDR_I[25:17] != 9'h000))
                    begin
                        nxt_rsp   = 1'b1;
                        nxt_rdata = DATA_RST;
                    end
                    else
                    begin
                        // Mode two marks a high-byte-only access with A0.
                        nxt_addr = {CMD_ADDR_I[16:1],
                                    MODE2_I ? !CMD_BYTE_EN_I[0] : CMD_ADDR_I[0]};
                        nxt_cs_n = 1'b0;
                        nxt_dout = CMD_WDATA_I;
                        nxt_doe  = CMD_WRITE_I;
                        nxt_st   = HS_SETUP;
                    end
                end
            HS_SETUP:
                if (cnt_ff == 5'(SETUP_CYCLES - 1))
                begin
                    nxt_stb = strobes(MODE2_I, wr_ff, be_ff);
                    nxt_cnt = 5'h00;
                    nxt_st  = HS_STROBE;
                end
            HS_STROBE:
                if (cnt_ff == 5'(SETTLE_CYCLES - 1))
                    nxt_st = HS_WAIT;
            HS_WAIT:
                if (wait_q)
                begin
                    nxt_rdata = wr_ff ? DATA_RST : bus.host_data_io;
                    nxt_rsp   = 1'b1;
                    nxt_stb   = 4'hF;
                    nxt_doe   = 1'b0;
                    nxt_cnt   = 5'h00;
                    nxt_st    = HS_RECOVER;
                end
            HS_RECOVER:
                // Chip select is held until the device has seen the strobes rise.
                if (cnt_ff == 5'(RECOVER_CYCLES - 1))
                begin
                    nxt_cs_n = 1'b1;
                    nxt_st   = HS_IDLE;
                end
            default:
                nxt_st = HS_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            st_ff       <= HS_IDLE;
            cnt_ff      <= 5'h00;
            div_ff      <= 2'h0;
            bclk_ff     <= 1'b0;
            cs_n_ff     <= 1'b1;
            addr_ff     <= 17'h0_0000;
            dout_ff     <= DATA_RST;
            doe_ff      <= 1'b0;
            stb_ff      <= 4'hF;
            wr_ff       <= 1'b0;
            be_ff       <= 2'h0;
            rsp_ff      <= 1'b0;
            rdata_ff    <= DATA_RST;
            cpu_wait_ff <= 1'b0;
        end
        else
        begin
            st_ff       <= nxt_st;
            cnt_ff      <= nxt_cnt;
            div_ff      <= nxt_div;
            bclk_ff     <= nxt_bclk;
            cs_n_ff     <= nxt_cs_n;
            addr_ff     <= nxt_addr;
            dout_ff     <= nxt_dout;
            doe_ff      <= nxt_doe;
            stb_ff      <= nxt_stb;
            wr_ff       <= nxt_wr;
            be_ff       <= nxt_be;
            rsp_ff      <= nxt_rsp;
            rdata_ff    <= nxt_rdata;
            cpu_wait_ff <= nxt_cpu_wait;
        end
    end

    assign bus.host_bus_clock_in       = bclk_ff;
    assign bus.cs_n                    = cs_n_ff;
    assign bus.host_addr_in            = addr_ff;
    assign bus.host_data_o             = dout_ff;
    assign bus.host_data_oe            = doe_ff;
    assign bus.low_byte_write_strobe_n = stb_ff[3];
    assign bus.high_byte_strobe_n      = stb_ff[2];
    assign bus.rd_n                    = stb_ff[1];
    assign bus.rd_wr_n                 = stb_ff[0];
    assign CMD_READY_O                 = (st_ff == HS_IDLE) && !rsp_ff;
    assign RSP_VALID_O                 = rsp_ff;
    assign RSP_RDATA_O                 = rdata_ff;
    assign CPU_WAIT_O                  = cpu_wait_ff;
endmodule // lcdhp_host
`default_nettype wire

// [dv/lcdhp_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module lcdhp_chk (
    // Link signals and reset
    input wire logic host_bus_clock_in,
    input wire logic RST_I,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic low_byte_write_strobe_n,
    input wire logic dev_data_oe,
    input wire logic wait_n_o,
    input wire logic wait_oe
);
    default clocking @(posedge host_bus_clock_in); endclocking
    default disable iff (RST_I);
    // The chip select is synchronised first, so the release is allowed a few link clocks.
    idle_wait_a: assert property (cs_n [*5] |-> !wait_oe)
        else $error("wait driven while idle");
    wait_start_a: assert property ($fell(rd_n) && !cs_n |-> ##[1:6] (wait_oe && !wait_n_o))
        else $error("no wait after read strobe");
    wait_bound_a: assert property (wait_oe && !wait_n_o |-> ##[1:30] wait_n_o)
        else $error("wait held too long");
    read_data_a: assert property ($rose(wait_n_o) && !rd_n |-> dev_data_oe)
        else $error("read data not driven at wait release");
    wait_sel_a: assert property ($rose(wait_oe) |-> !cs_n)
        else $error("wait driven without chip select");
    release_hold_a: assert property ($rose(wait_n_o) |=> wait_n_o [*3])
        else $error("wait reasserted too soon");
    write_sel_a: assert property (!low_byte_write_strobe_n |-> !cs_n)
        else $error("write strobe outside chip select");
    read_hold_a: assert property (wait_oe && !wait_n_o && !$past(rd_n) |-> !rd_n)
        else $error("read strobe dropped during wait");
endmodule // lcdhp_chk
`default_nettype wire

// [dv/lcdhp_test.sv]
`timescale 1ns/10ps
`default_nettype none
module lcdhp_test;
    import lcdhp_pkg::*;
    logic        ref_clk = 1'b0, rst = 1'b1, bs = 1'b0, endian = 1'b0, valid = 1'b0, wr = 1'b0;
    logic [25:0] addr = '0;
    logic [15:0] wdata = '0, rf_data, rdata;
    logic [1:0]  be = 2'b11;
    logic        rdy, rsp, en, m2, big, cw, rack, strict = 1'b0;
    int          n_fail = 0, check_count = 0;
    lcdhp_if     link ();
    lcdhp_device lcdhp_device_inst (.REF_CLK_I(ref_clk), .RST_I(rst), .bus(link.dev),
        .BUS_STATUS_STRAP_I(bs), .ENDIAN_STRAP_I(endian), .HOST_MODE_STRAPS_I(GENERIC_STRAPS),
        .REFRESH_REQ_I(1'b1), .REFRESH_ADDR_I(16'h0000), .REFRESH_DATA_O(rf_data),
        .REFRESH_ACK_O(rack), .CFG_ENABLED_O(en), .CFG_MODE2_O(m2), .CFG_BIG_ENDIAN_O(big));
    lcdhp_host lcdhp_host_inst (.REF_CLK_I(ref_clk), .RST_I(rst), .bus(link.host),
        .MODE2_I(bs), .STRICT_DECODE_I(strict), .CMD_VALID_I(valid), .CMD_WRITE_I(wr),
        .CMD_ADDR_I(addr), .CMD_WDATA_I(wdata), .CMD_BYTE_EN_I(be), .CMD_READY_O(rdy),
        .RSP_VALID_O(rsp), .RSP_RDATA_O(rdata), .CPU_WAIT_O(cw));
    lcdhp_chk lcdhp_chk_inst (.host_bus_clock_in(link.host_bus_clock_in), .RST_I(rst),
        .cs_n(link.cs_n), .rd_n(link.rd_n), .dev_data_oe(link.dev_data_oe),
        .low_byte_write_strobe_n(link.low_byte_write_strobe_n),
        .wait_n_o(link.wait_n_o), .wait_oe(link.wait_oe));
    initial forever #25 ref_clk = ~ref_clk;
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic op(input logic w, input logic [25:0] a, input logic [15:0] d,
                      input logic [1:0] b, output logic [15:0] q);
        int i;
        logic seen;
        for (i = 0; i < 200 && rdy !== 1'b1; i++) @(posedge ref_clk) #2;
        {wr, addr, wdata, be, valid} = {w, a, d, b, 1'b1};
        @(posedge ref_clk) #2 valid = 1'b0;
        seen = 1'b0;
        for (i = 0; i < 200 && rsp !== 1'b1; i++)
        begin
            @(posedge ref_clk) #2;
            seen = seen | cw;
        end
        if (rsp !== 1'b1)
        begin
            check("response", 16'h0001, 16'h0000);
            wrap_up();
        end
        else
        begin
            q = rdata;
            check("cpu wait idle", 16'h0000, 16'(cw));
            if (!strict)
                check("cpu wait seen", 16'h0001, 16'(seen));
        end
    endtask
    // The refresh port is always requesting word zero, so its data trails the memory.
    task automatic rf_check(input logic [15:0] exp);
        repeat (3) @(posedge ref_clk);
        #2 check("refresh data", exp, rf_data);
        check("refresh ack", 16'h0001, 16'(rack));
    endtask
    // A strap changes after release to show that it was latched.
    task automatic boot(input logic mode, input logic big_e);
        {rst, bs, endian} = {1'b1, mode, big_e};
        repeat (4) @(posedge ref_clk);
        #2 rst = 1'b0;
        repeat (20) @(posedge ref_clk);
        #2 endian = ~big_e;
        repeat (4) @(posedge ref_clk);
        #2;
        check("mode strap", 16'(mode), 16'(m2));
        check("endian strap", 16'(big_e), 16'(big));
        check("enabled", 16'h0001, 16'(en));
        $display("boot test done");
    endtask
    task automatic t_word();
        logic [15:0] q;
        op(1'b1, 26'h000_0000, 16'hA55A, 2'b11, q);
        op(1'b1, 26'h3FE_0000, 16'h00C3, 2'b01, q);
        op(1'b1, 26'h000_0000, 16'h7700, 2'b10, q);
        op(1'b0, 26'h000_0000, 16'h0000, 2'b11, q);
        check("byte lanes", 16'h77C3, q);
        rf_check(16'h77C3);
        op(1'b1, 26'h001_FFFE, 16'h6E91, 2'b11, q);
        op(1'b0, 26'h001_FFFE, 16'h0000, 2'b11, q);
        check("register", 16'h6E91, q);
        op(1'b1, 26'h001_3FFE, 16'h0F0F, 2'b11, q);
        op(1'b0, 26'h001_3FFE, 16'h0000, 2'b11, q);
        check("memory top", 16'h0F0F, q);
        op(1'b1, 26'h001_4000, 16'hFFFF, 2'b11, q);
        op(1'b0, 26'h001_4000, 16'h0000, 2'b11, q);
        check("unmapped", 16'h0000, q);
        $display("word test done");
    endtask
    task automatic t_endian();
        logic [15:0] q;
        op(1'b1, 26'h000_0000, 16'h1234, 2'b11, q);
        rf_check(16'h3412);
        strict = 1'b1;
        op(1'b1, 26'h002_0000, 16'hBEEF, 2'b11, q);
        check("strict miss", 16'h0000, q);
        strict = 1'b0;
        op(1'b0, 26'h000_0000, 16'h0000, 2'b11, q);
        check("endian read", 16'h1234, q);
        $display("endian test done");
    endtask
    initial
    begin
        boot(1'b0, 1'b0);
        t_word();
        boot(1'b1, 1'b0);
        t_word();
        boot(1'b1, 1'b1);
        t_endian();
        wrap_up();
    end
endmodule // lcdhp_test
`default_nettype wire
